// >>> hdl/djk_pkg.sv
// Purpose: shared constants for the dual j-k storage block
// Assumes: one system clock, synchronous pin sampling
// Notes: state encodings of the two steering inputs
package djk_pkg;
  localparam int DJK_NUM_FF = 2;
  localparam logic [1:0] DJK_JK_HOLD = 2'h0;
  localparam logic [1:0] DJK_JK_LOAD1 = 2'h2;
  localparam logic [1:0] DJK_JK_LOAD0 = 2'h1;
  localparam logic [1:0] DJK_JK_TOGGLE = 2'h3;
  localparam logic DJK_RST_VAL = 1'h0;
  localparam logic DJK_CLK_RST_VAL = 1'h0;
endpackage : djk_pkg

// >>> hdl/djk_dual_jk.sv
// Purpose: two independent negative-edge j-k storage elements
// Assumes: all pins synchronous to sys_clk; edges seen by sampling
// Notes: overrides act at the next sys_clk edge, only while clk_en is high; not truly async
// Operation
// R1: two independent elements, each with own steering, clock, overrides
// R2: low preset forces true high; low clear forces true low
// R3: both overrides low drives true and complement both high
// R4: driver must not release preset and clear in the same instant
// R5: steering may change while clock is high; pre-edge level counts
// R6: state changes only on falling clock edge, never on rising
// R7: both high toggles, 01 stores zero, 10 stores one, 00 holds
// R8: steering used is that held before the falling clock edge
// R9: single-override build has no clear; preset alone forces one
// R10: state is undefined after power-up until override or edge; the code instead loads zero while nrst is low
`timescale 1ns/1ns
module djk_dual_jk
  import djk_pkg::*;
#(
  parameter int NUM_FF = djk_pkg::DJK_NUM_FF,
  parameter bit HAS_CLEAR = 1'b1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [NUM_FF-1:0] j_in,
  input wire logic [NUM_FF-1:0] k_in,
  input wire logic [NUM_FF-1:0] falling_edge_clk,
  input wire logic [NUM_FF-1:0] preset_n,
  input wire logic [NUM_FF-1:0] clear_n,
  output logic [NUM_FF-1:0] q_out,
  output logic [NUM_FF-1:0] q_n_out
);
  import djk_pkg::*;

  typedef struct packed {
    logic [NUM_FF-1:0] clk_d;
    logic [NUM_FF-1:0] j_d;
    logic [NUM_FF-1:0] k_d;
    logic [NUM_FF-1:0] st;
    logic [NUM_FF-1:0] q;
    logic [NUM_FF-1:0] qn;
  } djk_state_t;

  djk_state_t state_ff;
  djk_state_t nxt_state;
  logic [NUM_FF-1:0] clr_eff_n;

  // the clear pin is simply ignored in the single-override build
  assign clr_eff_n = HAS_CLEAR ? clear_n : {NUM_FF{1'b1}}; // [R9]

  always_comb begin
    nxt_state = state_ff;
    nxt_state.clk_d = falling_edge_clk;
    // steering latched each cycle; value from the cycle before the edge
    nxt_state.j_d = j_in; // [R5] [R8]
    nxt_state.k_d = k_in; // [R5] [R8]
    for (int i = 0; i < NUM_FF; i++) begin // [R1]
      if (!preset_n[i] && !clr_eff_n[i]) begin
        // stored state left as is; outcome after release is undefined
        nxt_state.st[i] = state_ff.st[i]; // [R4]
        nxt_state.q[i] = 1'b1; // [R3]
        nxt_state.qn[i] = 1'b1; // [R3]
      end else if (!preset_n[i]) begin
        nxt_state.st[i] = 1'b1; // [R2] [R9]
        nxt_state.q[i] = 1'b1;
        nxt_state.qn[i] = 1'b0;
      end else if (!clr_eff_n[i]) begin
        nxt_state.st[i] = 1'b0; // [R2]
        nxt_state.q[i] = 1'b0;
        nxt_state.qn[i] = 1'b1;
      end else begin
        if (state_ff.clk_d[i] && !falling_edge_clk[i]) begin // [R6]
          unique case ({state_ff.j_d[i], state_ff.k_d[i]}) // [R7]
            DJK_JK_HOLD: nxt_state.st[i] = state_ff.st[i];
            DJK_JK_LOAD0: nxt_state.st[i] = 1'b0;
            DJK_JK_LOAD1: nxt_state.st[i] = 1'b1;
            DJK_JK_TOGGLE: nxt_state.st[i] = ~state_ff.st[i];
          endcase
        end
        nxt_state.q[i] = nxt_state.st[i];
        nxt_state.qn[i] = ~nxt_state.st[i];
      end
    end
  end

  // reset value stands in for the unknown power-up state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff.clk_d <= {NUM_FF{DJK_CLK_RST_VAL}};
      state_ff.j_d <= '0;
      state_ff.k_d <= '0;
      state_ff.st <= {NUM_FF{DJK_RST_VAL}}; // [R10]
      state_ff.q <= {NUM_FF{DJK_RST_VAL}};
      state_ff.qn <= {NUM_FF{~DJK_RST_VAL}};
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign q_out = state_ff.q;
  assign q_n_out = state_ff.qn;

  property p_both_low;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && !preset_n[0] && !clr_eff_n[0]) |=> (q_out[0] && q_n_out[0]);
  endproperty
  a_both_low: assert property (p_both_low) // [R3]
    else $error("both overrides low but outputs not both high");

  property p_preset;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && !preset_n[1] && clr_eff_n[1]) |=> (q_out[1] && !q_n_out[1]);
  endproperty
  a_preset: assert property (p_preset) // [R2]
    else $error("preset did not force true output high");

  property p_clear;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[0] && !clr_eff_n[0]) |=> (!q_out[0] && q_n_out[0]);
  endproperty
  a_clear: assert property (p_clear) // [R2]
    else $error("clear did not force true output low");

  property p_no_rise;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[0] && clr_eff_n[0]
      && !(state_ff.clk_d[0] && !falling_edge_clk[0]))
      |=> $stable(q_out[0]);
  endproperty
  a_no_rise: assert property (p_no_rise) // [R6]
    else $error("output changed without a falling clock edge");

  property p_toggle;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[0] && clr_eff_n[0] && state_ff.q[0] != state_ff.qn[0]
      && state_ff.clk_d[0] && !falling_edge_clk[0]
      && state_ff.j_d[0] && state_ff.k_d[0])
      |=> (q_out[0] != $past(q_out[0]));
  endproperty
  a_toggle: assert property (p_toggle) // [R7]
    else $error("toggle did not invert output");

  property p_load;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[1] && clr_eff_n[1]
      && state_ff.clk_d[1] && !falling_edge_clk[1]
      && (state_ff.j_d[1] != state_ff.k_d[1]))
      |=> (q_out[1] == $past(state_ff.j_d[1]) && q_n_out[1] == !q_out[1]);
  endproperty
  a_load: assert property (p_load) // [R7] [R8]
    else $error("load did not follow pre-edge steering");

  property p_freeze;
    @(posedge sys_clk) disable iff (!nrst)
    !clk_en |=> ($stable(q_out) && $stable(q_n_out));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while clock enable low");

  property p_no_clear_opt;
    @(posedge sys_clk) disable iff (!nrst)
    (!HAS_CLEAR && clk_en && !preset_n[0]) |=> (q_out[0] && !q_n_out[0]);
  endproperty
  a_no_clear_opt: assert property (p_no_clear_opt) // [R9]
    else $error("single-override preset failed");

  // second element mirrors the first; catches cross-talk between them
  property p_no_rise1;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[1] && clr_eff_n[1]
      && !(state_ff.clk_d[1] && !falling_edge_clk[1]))
      |=> $stable(q_out[1]);
  endproperty
  a_no_rise1: assert property (p_no_rise1) // [R1] [R6]
    else $error("second output changed without its falling clock edge");

  property p_both_low1;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && !preset_n[1] && !clr_eff_n[1]) |=> (q_out[1] && q_n_out[1]);
  endproperty
  a_both_low1: assert property (p_both_low1) // [R1] [R3]
    else $error("second element not both high with both overrides low");

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[0] && clr_eff_n[0] && state_ff.q[0] != state_ff.qn[0]
      && state_ff.clk_d[0] && !falling_edge_clk[0]
      && !state_ff.j_d[0] && !state_ff.k_d[0])
      |=> $stable(q_out[0]);
  endproperty
  a_hold: assert property (p_hold) // [R7]
    else $error("hold steering changed the output");

  property p_load0;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && preset_n[0] && clr_eff_n[0]
      && state_ff.clk_d[0] && !falling_edge_clk[0]
      && (state_ff.j_d[0] != state_ff.k_d[0]))
      |=> (q_out[0] == $past(state_ff.j_d[0]) && q_n_out[0] == !q_out[0]);
  endproperty
  a_load0: assert property (p_load0) // [R7] [R8]
    else $error("first element load did not follow pre-edge steering");

  // outputs only agree while both overrides are held low together
  property p_compl;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && (preset_n[0] || clr_eff_n[0])) |=> (q_out[0] != q_n_out[0]);
  endproperty
  a_compl: assert property (p_compl) // [R2] [R7]
    else $error("outputs not complementary outside both-low override");

  // a stray clear pin must not disturb the single-override build
  property p_clear_ignored;
    @(posedge sys_clk) disable iff (!nrst)
    (!HAS_CLEAR && clk_en && preset_n[0] && !clear_n[0]
      && !(state_ff.clk_d[0] && !falling_edge_clk[0]))
      |=> $stable(q_out[0]);
  endproperty
  a_clear_ignored: assert property (p_clear_ignored) // [R9]
    else $error("clear pin acted in the single-override build");

  c_toggle: cover property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && preset_n[0] && clr_eff_n[0] && state_ff.clk_d[0]
      && !falling_edge_clk[0] && state_ff.j_d[0] && state_ff.k_d[0]);
  c_both_low: cover property (@(posedge sys_clk) disable iff (!nrst)
    !preset_n[1] && !clr_eff_n[1]);
  c_load1: cover property (@(posedge sys_clk) disable iff (!nrst)
    ##1 q_out[1] && $rose(q_out[1]) && preset_n[1]);
  c_freeze: cover property (@(posedge sys_clk) disable iff (!nrst)
    !clk_en && falling_edge_clk[0]);
  c_clear_ignored: cover property (@(posedge sys_clk) disable iff (!nrst)
    !HAS_CLEAR && preset_n[0] && !clear_n[0]);
endmodule : djk_dual_jk

// >>> verif/djk_far_end.sv
// Purpose: far-side driver of steering and element clocks
// Assumes: go held high two sys_clk cycles per pulse
// Notes: steering starts wrong, settles while clock high
`timescale 1ns/1ns
module djk_far_end (
  input wire logic sys_clk,
  input wire logic [1:0] go,
  input wire logic [1:0] j_want,
  input wire logic [1:0] k_want,
  output logic [1:0] fclk,
  output logic [1:0] j,
  output logic [1:0] k
);
  logic [1:0] g;
  logic [1:0] jw_s;
  logic [1:0] kw_s;
  initial fclk = 2'h0;
  always @(posedge sys_clk) begin
    g = go;
    // wanted levels taken at the edge, clear of the bench's own update
    jw_s = j_want;
    kw_s = k_want;
    #2;
    // wrong levels first, only settled ones may count
    j = jw_s ^ (g & ~fclk);
    k = kw_s ^ (g & ~fclk);
    fclk = g;
  end
endmodule : djk_far_end

// >>> verif/tb_djk_dual_jk.sv
// Purpose: self-checking bench for the dual j-k block
// Assumes: 50 MHz sys_clk, inputs moved 2 ns after rising edge
// Notes: second instance covers the build without clear
`timescale 1ns/1ns
module tb_djk_dual_jk;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] go = 2'h0, jw = 2'h0, kw = 2'h0, pre_n = 2'h3, clr_n = 2'h3;
  logic [1:0] fclk, j, k, q, qn, q2, qn2;
  logic en = 1'b1;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // rows of {j, k, expected q}
  localparam logic [2:0] ROWS [6] = '{3'h5, 3'h1, 3'h6, 3'h7, 3'h2, 3'h0};
  always #10 sys_clk = ~sys_clk;
  djk_far_end i_far (.sys_clk(sys_clk), .go(go), .j_want(jw), .k_want(kw),
    .fclk(fclk), .j(j), .k(k));
  djk_dual_jk i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(en),
    .j_in(j), .k_in(k), .falling_edge_clk(fclk), .preset_n(pre_n),
    .clear_n(clr_n), .q_out(q), .q_n_out(qn));
  djk_dual_jk #(.HAS_CLEAR(1'b0)) i_one (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(en), .j_in(j), .k_in(k), .falling_edge_clk(fclk),
    .preset_n(pre_n), .clear_n(clr_n), .q_out(q2), .q_n_out(qn2));
  task stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : wt
  task pulse(input logic [1:0] e, input logic [1:0] jv, input logic [1:0] kv);
    go = e;
    jw = jv;
    kw = kv;
    wt(2);
    go = 2'h0;
    wt(4);
  endtask : pulse
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    wt(16);
    chk("q reset", 2'h0, q);
    chk("qn reset", 2'h3, qn);
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      pulse(2'h3, {2{ROWS[i][2]}}, {2{ROWS[i][1]}});
      chk("q step", {2{ROWS[i][0]}}, q);
      chk("qn step", {2{~ROWS[i][0]}}, qn);
    end
    $display("test steering done");
    pulse(2'h1, 2'h3, 2'h3);
    chk("q one element", 2'h1, q);
    go = 2'h2;
    jw = 2'h3;
    kw = 2'h0;
    wt(5);
    chk("q clock high", 2'h1, q);
    go = 2'h0;
    wt(4);
    chk("q clock fell", 2'h3, q);
    $display("test edges done");
    en = 1'b0;
    pulse(2'h3, 2'h3, 2'h3);
    chk("q frozen", 2'h3, q);
    en = 1'b1;
    wt(2);
    chk("q thawed", 2'h3, q);
    chk("qn thawed", 2'h0, qn);
    $display("test enable done");
    clr_n = 2'h0;
    wt(2);
    chk("q clear", 2'h0, q);
    chk("q2 clear", 2'h3, q2);
    pre_n = 2'h0;
    wt(2);
    chk("q both", 2'h3, q);
    chk("qn both", 2'h3, qn);
    pre_n = 2'h3; // preset freed before clear
    wt(2);
    chk("qn clear", 2'h3, qn);
    clr_n = 2'h3;
    pulse(2'h3, 2'h0, 2'h3);
    pre_n = 2'h0;
    wt(2);
    chk("qn preset", 2'h0, qn);
    chk("q2 preset", 2'h3, q2);
    chk("qn2 preset", 2'h0, qn2);
    $display("test overrides done");
    nrst = 1'b0;
    pre_n = 2'h3;
    wt(1);
    chk("q mid reset", 2'h0, q);
    chk("qn mid reset", 2'h3, qn);
    nrst = 1'b1;
    wt(2);
    chk("q after reset", 2'h0, q);
    chk("q2 after reset", 2'h0, q2);
    $display("test reset done");
    stop_test();
  end
endmodule : tb_djk_dual_jk
